// file: hw/status_pkg.sv
// package: constants and register map of the status event aggregator
package status_pkg;
    // ****************************************************************
    // register selectors on the command port
    // ****************************************************************
    localparam logic [2:0] SEL_PPE      = 3'h0;
    localparam logic [2:0] SEL_DEV_COND = 3'h1;
    localparam logic [2:0] SEL_DEV_EVT  = 3'h2;
    localparam logic [2:0] SEL_QUE_COND = 3'h3;
    localparam logic [2:0] SEL_QUE_EVT  = 3'h4;
    localparam logic [2:0] SEL_ESR      = 3'h5;
    localparam logic [2:0] SEL_ESE      = 3'h6;
    localparam logic [2:0] SEL_IST      = 3'h7;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int DEV_CONN_A  = 1;
    localparam int DEV_CONN_B  = 2;
    localparam int DEV_ERR_A   = 3;
    localparam int DEV_ERR_B   = 4;
    localparam int DEV_REAR_A  = 5;
    localparam int DEV_REAR_B  = 6;
    localparam int DEV_CONN_C  = 7;
    localparam int DEV_CONN_D  = 8;
    localparam int DEV_ERR_C   = 9;
    localparam int DEV_ERR_D   = 10;
    localparam int DEV_REAR_C  = 11;
    localparam int DEV_REAR_D  = 12;
    localparam int DEV_KEY     = 14;
    localparam int QUE_POWER   = 3;
    localparam int QUE_WINDOW  = 4;
    localparam int QUE_CAL     = 8;
    localparam int QUE_POST    = 9;
    localparam int QUE_WARN    = 14;
    localparam int ESR_OPC     = 0;
    localparam int ESR_QUERY   = 2;
    localparam int ESR_DEVDEP  = 3;
    localparam int ESR_EXEC    = 4;
    localparam int ESR_CMD     = 5;
    localparam int ESR_USER    = 6;
    localparam int ESR_PON     = 7;
    localparam int STB_DEV     = 1;
    localparam int STB_QUE     = 3;
    localparam int STB_ESB     = 5;

    // ****************************************************************
    // masks of used bits and reset values
    // ****************************************************************
    localparam logic [15:0] DEV_USED_MASK = 16'h5ffe;
    localparam logic [15:0] QUE_USED_MASK = 16'h4318;
    localparam logic [7:0]  ESR_USED_MASK = 8'hfd;
    localparam logic [7:0]  PPE_RESET     = 8'h00;
    localparam logic [7:0]  ESE_RESET     = 8'h00;
    localparam logic [15:0] EVT16_RESET   = 16'h0000;
    localparam logic [7:0]  ESR_RESET     = 8'h80;

    // ****************************************************************
    // error numbers queued per error class
    // ****************************************************************
    localparam logic signed [15:0] ERRNO_CMD    = -16'sd100;
    localparam logic signed [15:0] ERRNO_EXEC   = -16'sd200;
    localparam logic signed [15:0] ERRNO_DEVDEP = -16'sd300;
endpackage

// file: hw/event_bus_if.sv
// interface: condition, event and summary signals of one event register
`timescale 1ns/1ps
interface event_bus_if #(parameter int W = 16);
    logic [W-1:0] cond;
    logic [W-1:0] used;
    logic [W-1:0] enable;
    logic         clear;
    logic [W-1:0] event_q;
    logic         summary;
    modport owner (input cond, used, enable, clear,
                   output event_q, summary);
    modport user  (output cond, used, enable, clear,
                   input event_q, summary);
endinterface

// file: hw/event_latch.sv
// module: sticky event register with enable-gated summary
`timescale 1ns/1ps
module event_latch #(parameter int W = 16) (
    // clock and reset
    input wire logic  clk,
    input wire logic  rst_b,
    // event register signals
    event_bus_if.owner eb
);
    logic [W-1:0] evt;
    logic [W-1:0] next_evt;
    logic         sum;

    // ****************************************************************
    // latch and read clear, a new event wins over the clear
    // ****************************************************************
    assign next_evt = ((eb.clear ? '0 : evt) | eb.cond) & eb.used;
    assign eb.event_q = evt;
    assign eb.summary = sum;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evt <= '0;
            sum <= 1'b0;
        end else begin
            evt <= next_evt;
            sum <= |(next_evt & eb.enable);
        end
    end
endmodule

// file: hw/status_event_aggregator.sv
// module: status reporting logic of a multi-sensor measuring instrument
//
// Operation
// - ist is or of stb and ppe
// - ist on parallel poll and query
// - ppe mask written and read back
// - device condition live, event latched since read
// - connected and error bits per sensor
// - front or rear port bits per sensor
// - key bit held and latched
// - bit 15 always reads zero
// - power window calibration summaries in questionable
// - bit 9 set on self test failure
// - esr event register read by query
// - ese enables esr summary, written read
// - esr bit 0 after opc completes
// - esr bit 2 on query error
// - esr bit 3 device error, queue number unless exec or cmd error in same cycle
// - esr bit 4 execution error, queue number unless cmd error in same cycle
// - esr bit 5 command error, queue number
// - esr bit 6 on local key
// - esr bit 7 at switch on
// - event read returns then clears
// - summary is or of enabled events
// - stb bit 5 from enabled esr bits
`timescale 1ns/1ps
module status_event_aggregator
    import status_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    // sensor and panel pins
    input  wire logic [3:0]         sensor_conn,
    input  wire logic [3:0]         sensor_err,
    input  wire logic [3:0]         sensor_rear,
    input  wire logic               key_held,
    input  wire logic               local_key,
    input  wire logic               post_fail,
    input  wire logic               warn,
    // sub-register summaries and other status byte sources
    input  wire logic               power_summary,
    input  wire logic               window_summary,
    input  wire logic               cal_summary,
    input  wire logic [7:0]         stb_other,
    // command engine events
    input  wire logic               opc_done,
    input  wire logic               query_err,
    input  wire logic               devdep_err,
    input  wire logic               exec_err,
    input  wire logic               cmd_err,
    // register command port
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [2:0]         reg_sel,
    input  wire logic [15:0]        reg_wdata,
    output logic [15:0]             reg_rdata,
    output logic                    reg_rvalid,
    // parallel poll
    input  wire logic               ppoll,
    output logic                    ist_resp,
    // status byte summaries
    output logic                    dev_summary,
    output logic                    que_summary,
    output logic                    esb,
    // error queue entry
    output logic                    err_push,
    output logic signed [15:0]      err_num
);
    // ****************************************************************
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    // ****************************************************************
    localparam int NPIN = 20;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] pin_q;
    logic [NPIN-1:0] next_pin_q;

    assign pin_raw = {warn, post_fail, local_key, key_held,
                      sensor_rear, sensor_err, sensor_conn,
                      power_summary, window_summary, cal_summary, 1'b0};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            assign next_pin_q[g] = (s2[g] == s3[g]) ? s3[g] : pin_q[g];
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            pin_q <= '0;
        end else begin
            s1    <= pin_raw;
            s2    <= s1;
            s3    <= s2;
            pin_q <= next_pin_q;
        end
    end

    logic       cal_q;
    logic       win_q;
    logic       pow_q;
    logic [3:0] conn_q;
    logic [3:0] err_q;
    logic [3:0] rear_q;
    logic       key_q;
    logic       lkey_q;
    logic       post_q;
    logic       warn_q;
    assign cal_q  = pin_q[1];
    assign win_q  = pin_q[2];
    assign pow_q  = pin_q[3];
    assign conn_q = pin_q[7:4];
    assign err_q  = pin_q[11:8];
    assign rear_q = pin_q[15:12];
    assign key_q  = pin_q[16];
    assign lkey_q = pin_q[17];
    assign post_q = pin_q[18];
    assign warn_q = pin_q[19];

    // ****************************************************************
    // writable ppe and ese masks, fixed device and questionable enables
    // ****************************************************************
    logic [7:0]  parallel_poll_enable;
    logic [7:0]  standard_event_enable;
    logic [15:0] dev_en;
    logic [15:0] que_en;
    logic        wr_ppe;
    logic        wr_ese;
    assign wr_ppe = reg_wr && reg_sel == SEL_PPE;
    assign wr_ese = reg_wr && reg_sel == SEL_ESE;
    assign dev_en = DEV_USED_MASK;
    assign que_en = QUE_USED_MASK;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            parallel_poll_enable <= PPE_RESET;
            standard_event_enable <= ESE_RESET;
        end else begin
            if (wr_ppe) parallel_poll_enable <= reg_wdata[7:0];
            if (wr_ese) standard_event_enable <= reg_wdata[7:0];
        end
    end

    // ****************************************************************
    // device status condition and event
    // ****************************************************************
    logic [15:0] dev_cond;
    assign dev_cond = {1'b0, key_q, 1'b0,
                       rear_q[3], rear_q[2],
                       err_q[3], err_q[2],
                       conn_q[3], conn_q[2],
                       rear_q[1], rear_q[0],
                       err_q[1], err_q[0],
                       conn_q[1], conn_q[0], 1'b0};

    event_bus_if #(.W(16)) dev_bus ();
    assign dev_bus.cond   = dev_cond;
    assign dev_bus.used   = DEV_USED_MASK;
    assign dev_bus.enable = dev_en;
    assign dev_bus.clear  = reg_rd && reg_sel == SEL_DEV_EVT;
    event_latch #(.W(16)) u_dev (
        .clk   (clk),
        .rst_b (rst_b),
        .eb    (dev_bus)
    );

    // ****************************************************************
    // questionable status condition and event
    // ****************************************************************
    logic [15:0] que_cond;
    assign que_cond = {1'b0, warn_q, 4'h0, post_q,
                       cal_q, 3'h0, win_q, pow_q, 3'h0};

    event_bus_if #(.W(16)) que_bus ();
    assign que_bus.cond   = que_cond;
    assign que_bus.used   = QUE_USED_MASK;
    assign que_bus.enable = que_en;
    assign que_bus.clear  = reg_rd && reg_sel == SEL_QUE_EVT;
    event_latch #(.W(16)) u_que (
        .clk   (clk),
        .rst_b (rst_b),
        .eb    (que_bus)
    );

    // ****************************************************************
    // standard event status register
    // ****************************************************************
    logic [7:0] standard_event_status;
    logic [7:0] next_esr;
    logic [7:0] esr_set;
    logic       lkey_d;
    logic       esr_clr;
    assign esr_clr = reg_rd && reg_sel == SEL_ESR;
    assign esr_set = {1'b0,
                      lkey_q & ~lkey_d,
                      cmd_err,
                      exec_err,
                      devdep_err,
                      query_err,
                      1'b0,
                      opc_done};
    assign next_esr = ((esr_clr ? 8'h00 : standard_event_status) | esr_set)
                      & ESR_USED_MASK;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            standard_event_status    <= ESR_RESET;
            lkey_d <= 1'b0;
        end else begin
            standard_event_status    <= next_esr;
            lkey_d <= lkey_q;
        end
    end

    // ****************************************************************
    // error queue entry
    // ****************************************************************
    logic               next_push;
    logic signed [15:0] next_num;
    assign next_push = cmd_err | exec_err | devdep_err;
    assign next_num  = cmd_err  ? ERRNO_CMD :
                       exec_err ? ERRNO_EXEC :
                                  ERRNO_DEVDEP;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            err_push <= 1'b0;
            err_num  <= 16'sh0000;
        end else begin
            err_push <= next_push;
            if (next_push) err_num <= next_num;
        end
    end

    // ****************************************************************
    // summaries, status byte and ist
    // ****************************************************************
    logic       esb_now;
    logic [7:0] stb;
    logic       ist_now;
    assign esb_now = |(standard_event_status & standard_event_enable);
    assign stb = {stb_other[7:6], esb_now, stb_other[4],
                  que_bus.summary, stb_other[2],
                  dev_bus.summary, 1'b0};
    assign ist_now = |(stb & parallel_poll_enable);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dev_summary <= 1'b0;
            que_summary <= 1'b0;
            esb         <= 1'b0;
            ist_resp    <= 1'b0;
        end else begin
            dev_summary <= dev_bus.summary;
            que_summary <= que_bus.summary;
            esb         <= esb_now;
            ist_resp    <= ppoll & ist_now;
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    logic [15:0] rd_mux;
    assign rd_mux = (reg_sel == SEL_PPE)      ? {8'h00, parallel_poll_enable} :
                    (reg_sel == SEL_DEV_COND) ? dev_cond :
                    (reg_sel == SEL_DEV_EVT)  ? dev_bus.event_q :
                    (reg_sel == SEL_QUE_COND) ? que_cond :
                    (reg_sel == SEL_QUE_EVT)  ? que_bus.event_q :
                    (reg_sel == SEL_ESR)      ? {8'h00, standard_event_status} :
                    (reg_sel == SEL_ESE)      ? {8'h00, standard_event_enable} :
                    {15'h0000, ist_now};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) reg_rdata <= rd_mux;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_esr_read;
        reg_rd && reg_sel == SEL_ESR && esr_set == 8'h00;
    endsequence

    property p_ist;
        @(posedge clk) disable iff (!rst_b)
        ppoll |=> ist_resp == $past(ist_now);
    endproperty
    a_ist: assert property (p_ist) else $error("ist mismatch");

    sequence s_ppe_wr_rd;
        wr_ppe ##1 !reg_wr ##1 (reg_rd && reg_sel == SEL_PPE && !reg_wr);
    endsequence

    property p_ppe_back;
        @(posedge clk) disable iff (!rst_b)
        s_ppe_wr_rd |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 3);
    endproperty
    a_ppe_back: assert property (p_ppe_back)
        else $error("ppe readback wrong");

    property p_esr_clear;
        @(posedge clk) disable iff (!rst_b)
        s_esr_read |=> standard_event_status == 8'h00 && reg_rdata[7:0] == $past(standard_event_status);
    endproperty
    a_esr_clear: assert property (p_esr_clear)
        else $error("esr not cleared on read");

    property p_cmd_err;
        @(posedge clk) disable iff (!rst_b)
        cmd_err |=> standard_event_status[ESR_CMD] && err_push && err_num == ERRNO_CMD;
    endproperty
    a_cmd_err: assert property (p_cmd_err)
        else $error("command error not flagged");

    property p_opc;
        @(posedge clk) disable iff (!rst_b)
        opc_done |=> standard_event_status[ESR_OPC];
    endproperty
    a_opc: assert property (p_opc) else $error("opc bit missing");

    property p_unused;
        @(posedge clk) disable iff (!rst_b)
        (dev_bus.event_q & ~DEV_USED_MASK) == 16'h0000
        && (que_bus.event_q & ~QUE_USED_MASK) == 16'h0000
        && !standard_event_status[1];
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused bit set");

    property p_esb;
        @(posedge clk) disable iff (!rst_b)
        |(standard_event_status & standard_event_enable) |=> esb;
    endproperty
    a_esb: assert property (p_esb) else $error("esb not set");

    property p_key_latch;
        @(posedge clk) disable iff (!rst_b)
        key_q |=> dev_bus.event_q[DEV_KEY];
    endproperty
    a_key_latch: assert property (p_key_latch)
        else $error("key event lost");
endmodule

// file: sim/bus_controller.sv
// partner model: remote bus controller issuing register commands
`timescale 1ns/1ps
module bus_controller (
    // clock
    input  wire logic        clk,
    // register command port
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [2:0]       reg_sel,
    output logic [15:0]      reg_wdata,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_sel   = 3'h0;
        reg_wdata = 16'h0000;
    end

    // one write, entered just after a rising edge; idle lines toggle
    task automatic write_reg(input logic [2:0] sel,
                             input logic [15:0] d);
        reg_wr    = 1'b1;
        reg_sel   = sel;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr    = 1'b0;
        reg_sel   = ~sel;
        reg_wdata = ~d;
        @(posedge clk);
        #1;
    endtask

    // one read, data taken with the valid pulse
    task automatic read_reg(input logic [2:0] sel,
                            output logic [15:0] d,
                            output logic vld);
        reg_rd  = 1'b1;
        reg_sel = sel;
        @(posedge clk);
        #1;
        d       = reg_rdata;
        vld     = reg_rvalid;
        reg_rd  = 1'b0;
        reg_sel = ~sel;
        @(posedge clk);
        #1;
    endtask
endmodule

// file: sim/testbench.sv
// testbench: scenario tests of the status event aggregator
`timescale 1ns/1ps
module testbench;
    import status_pkg::*;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  sensor_conn = 4'h0;
    logic [3:0]  sensor_err = 4'h0;
    logic [3:0]  sensor_rear = 4'h0;
    logic        key_held = 1'b0;
    logic        local_key = 1'b0;
    logic        post_fail = 1'b0;
    logic        warn = 1'b0;
    logic        power_summary = 1'b0;
    logic        window_summary = 1'b0;
    logic        cal_summary = 1'b0;
    logic [7:0]  stb_other = 8'h00;
    logic [4:0]  evt = 5'h00;
    logic        ppoll = 1'b0;
    logic        reg_wr;
    logic        reg_rd;
    logic [2:0]  reg_sel;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        reg_rvalid;
    logic        ist_resp;
    logic        dev_summary;
    logic        que_summary;
    logic        esb;
    logic        err_push;
    logic [15:0] err_num;
    int          bad_count = 0;
    int          num_checks = 0;

    always #10 clk = ~clk;

    status_event_aggregator u_dut (
        .clk(clk), .rst_b(rst_b), .sensor_conn(sensor_conn),
        .sensor_err(sensor_err), .sensor_rear(sensor_rear),
        .key_held(key_held), .local_key(local_key),
        .post_fail(post_fail), .warn(warn),
        .power_summary(power_summary), .window_summary(window_summary),
        .cal_summary(cal_summary), .stb_other(stb_other),
        .opc_done(evt[0]), .query_err(evt[1]), .devdep_err(evt[2]),
        .exec_err(evt[3]), .cmd_err(evt[4]), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ppoll(ppoll),
        .ist_resp(ist_resp), .dev_summary(dev_summary),
        .que_summary(que_summary), .esb(esb), .err_push(err_push),
        .err_num(err_num));

    bus_controller u_host (
        .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rd_chk(input string nm, input logic [2:0] sel,
                          input logic [15:0] exp);
        logic [15:0] d;
        logic        v;
        u_host.read_reg(sel, d, v);
        check({nm, " valid"}, {15'h0, v}, 16'h0001);
        check(nm, d, exp);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        rd_chk("ppe", SEL_PPE, 16'h0000);
        rd_chk("ese", SEL_ESE, 16'h0000);
        rd_chk("esr", SEL_ESR, 16'h0080);
        rd_chk("esr", SEL_ESR, 16'h0000);
    endtask

    task automatic t_ist;
        stb_other = 8'h80;
        u_host.write_reg(SEL_PPE, 16'h0040);
        rd_chk("ppe", SEL_PPE, 16'h0040);
        rd_chk("ist", SEL_IST, 16'h0000);
        stb_other = 8'h40;
        rd_chk("ist", SEL_IST, 16'h0001);
        ppoll = 1'b1;
        tick(1);
        check("ist_resp", {15'h0, ist_resp}, 16'h0001);
        stb_other = 8'h01;
        u_host.write_reg(SEL_PPE, 16'h0001);
        check("ist_resp", {15'h0, ist_resp}, 16'h0000);
        rd_chk("ist", SEL_IST, 16'h0000);
        ppoll = 1'b0;
        stb_other = 8'h00;
        u_host.write_reg(SEL_PPE, 16'h0000);
    endtask

    task automatic t_device(input logic [3:0] c, input logic [3:0] e,
                            input logic [3:0] r, input logic k,
                            input logic [15:0] exp);
        {sensor_conn, sensor_err, sensor_rear, key_held} = {c, e, r, k};
        tick(6);
        rd_chk("dev_cond", SEL_DEV_COND, exp);
        check("dev_sum", {15'h0, dev_summary}, 16'h0001);
        {sensor_conn, sensor_err, sensor_rear, key_held} = 13'h0;
        tick(6);
        rd_chk("dev_cond", SEL_DEV_COND, 16'h0000);
        rd_chk("dev_evt", SEL_DEV_EVT, exp);
        rd_chk("dev_evt", SEL_DEV_EVT, 16'h0000);
        check("dev_sum", {15'h0, dev_summary}, 16'h0000);
    endtask

    task automatic t_quest;
        {power_summary, window_summary, cal_summary} = 3'h7;
        {post_fail, warn} = 2'h3;
        tick(6);
        rd_chk("que_cond", SEL_QUE_COND, 16'h4318);
        check("que_sum", {15'h0, que_summary}, 16'h0001);
        {power_summary, window_summary, cal_summary} = 3'h0;
        {post_fail, warn} = 2'h0;
        tick(6);
        rd_chk("que_evt", SEL_QUE_EVT, 16'h4318);
        rd_chk("que_evt", SEL_QUE_EVT, 16'h0000);
    endtask

    task automatic t_events;
        // error numbers -300, -200, -100 for the three error classes
        logic [15:0] num [5] = '{16'h0, 16'h0, 16'hfed4, 16'hff38,
                                 16'hff9c};
        for (int i = 0; i < 5; i++) begin
            evt = 5'h01 << i;
            tick(1);
            evt = 5'h00;
            check("err_push", {15'h0, err_push}, {15'h0, i > 1});
            if (i > 1)
                check("err_num", err_num, num[i]);
            tick(1);
        end
        local_key = 1'b1;
        tick(6);
        local_key = 1'b0;
        check("esb", {15'h0, esb}, 16'h0000);
        u_host.write_reg(SEL_ESE, 16'h0020);
        check("esb", {15'h0, esb}, 16'h0001);
        rd_chk("ese", SEL_ESE, 16'h0020);
        rd_chk("esr", SEL_ESR, 16'h007d);
        check("esb", {15'h0, esb}, 16'h0000);
        u_host.write_reg(SEL_ESR, 16'h00ff);
        rd_chk("esr", SEL_ESR, 16'h0000);
        u_host.write_reg(SEL_ESE, 16'h0000);
    endtask

    // ****************************************************************
    // sequence and watchdog
    // ****************************************************************
    initial begin
        tick(20);
        rst_b = 1'b1;
        tick(2);
        t_reset();
        t_ist();
        t_device(4'ha, 4'h5, 4'h9, 1'b1, 16'h532c);
        t_device(4'h5, 4'ha, 4'h6, 1'b0, 16'h0cd2);
        t_quest();
        t_events();
        print_verdict();
    end

    initial begin
        #200us;
        bad_count++;
        print_verdict();
    end
endmodule
